// ### crm_defs.svh
`ifndef CRM_DEFS_SVH
`define CRM_DEFS_SVH

// ==========================================
// Memory-mapped register addresses
`define CRM_ADDR_XHIGH 8'hBE
`define CRM_ADDR_XLOW 8'hBF
`define CRM_ADDR_STACK 8'hBD
`define CRM_ADDR_FLAGS 8'hBC

// ==========================================
// Stack window and reset values
`define CRM_STACK_BASE 8'h30
`define CRM_SP_RESET 4'hF
`define CRM_PC_RESET 12'h800
`define CRM_FLAGS_RESET 8'h00
`define CRM_FLAGS_MASK 8'h3F

// ==========================================
// Condition flag bit positions
`define CRM_FLAG_C 0
`define CRM_FLAG_H 1
`define CRM_FLAG_Z 2
`define CRM_FLAG_N 3
`define CRM_FLAG_G 4
`define CRM_FLAG_R 5

// ==========================================
// Index pointer layout
`define CRM_XSEL_BIT 11
`define CRM_XHIGH_SEL_BIT 3

`endif

// ### crm_pkg.sv
package crm_pkg;

  // ==========================================
  // Operations issued by the execution unit
  typedef enum logic [4:0] {
    OP_NOP, OP_LDA, OP_ADD, OP_ADC, OP_SUBC, OP_AND, OP_OR, OP_XOR,
    OP_INC, OP_DEC, OP_CLR, OP_RLC, OP_RRC, OP_SETC, OP_CLRC,
    OP_FLIPC, OP_BITC, OP_SETG, OP_CLRG, OP_LDX, OP_INCX, OP_DECX,
    OP_IDX_RD, OP_IDX_WR, OP_CALL, OP_RET
  } crm_op_t;

  // ==========================================
  // Call and return sequencer
  typedef enum logic [2:0] {
    ST_IDLE, ST_PUSH_HI, ST_POP_LO, ST_POP_WAIT, ST_POP_END
  } crm_seq_t;

  // ==========================================
  // Whole state of the register model
  typedef struct packed {
    logic [7:0] acc;
    logic x_sel;
    logic [10:0] x_low;
    logic [10:0] pc;
    logic [3:0] sp;
    logic [7:0] flags;
    crm_seq_t seq;
    logic busy;
    logic [7:0] tmp;
    logic [11:0] ea_addr;
    logic ea_rd;
    logic ea_wr;
    logic ea_blocked;
    logic [7:0] stk_addr;
    logic stk_rd;
    logic stk_wr;
    logic [7:0] stk_wdata;
    logic [7:0] rdata;
    logic map_hit;
    logic mode_meta;
    logic mode_sync;
  } crm_state_t;

endpackage : crm_pkg

// ### crm_flag_unit.sv
`timescale 1ns/1ps

module crm_flag_unit
  import crm_pkg::*;
(
  // Operation
  input wire crm_op_t op_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] operand_in,
  input wire logic carry_in,
  // Result and flags
  output logic [7:0] result_out,
  output logic carry_out,
  output logic half_out,
  output logic acc_we_out,
  output logic arith_out,
  output logic zn_out
);

  // Nine-bit add with carry in, shared by the adding operations
  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                     input logic ci);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
  endfunction : add9

  // Nibble carry of the same sum
  function automatic logic nib_carry(input logic [7:0] a, input logic [7:0] b,
                                     input logic ci);
    logic [4:0] s;
    s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    nib_carry = s[4];
  endfunction : nib_carry

  // Datapath and flag sources
  always_comb begin
    logic [8:0] sum;
    sum = 9'h000;
    result_out = acc_in;
    carry_out = carry_in;
    half_out = 1'b0;
    acc_we_out = 1'b1;
    arith_out = 1'b0;
    zn_out = 1'b1;
    unique case (op_in)
      OP_LDA: result_out = operand_in;
      OP_ADD, OP_ADC: begin
        sum = add9(acc_in, operand_in, (op_in == OP_ADC) & carry_in);
        result_out = sum[7:0];
        carry_out = sum[8];
        half_out = nib_carry(acc_in, operand_in, (op_in == OP_ADC) & carry_in);
        arith_out = 1'b1;
      end
      OP_SUBC: begin
        // Carry in and out mean borrow
        sum = add9(acc_in, ~operand_in, ~carry_in);
        result_out = sum[7:0];
        carry_out = ~sum[8];
        half_out = ~nib_carry(acc_in, ~operand_in, ~carry_in);
        arith_out = 1'b1;
      end
      OP_AND: result_out = acc_in & operand_in;
      OP_OR: result_out = acc_in | operand_in;
      OP_XOR: result_out = acc_in ^ operand_in;
      OP_INC: result_out = acc_in + 8'h01;
      OP_DEC: result_out = acc_in - 8'h01;
      OP_CLR: result_out = 8'h00;
      OP_RLC: begin
        result_out = {acc_in[6:0], carry_in};
        carry_out = acc_in[7];
      end
      OP_RRC: begin
        result_out = {carry_in, acc_in[7:1]};
        carry_out = acc_in[0];
      end
      default: begin
        acc_we_out = 1'b0;
        zn_out = 1'b0;
      end
    endcase
  end

endmodule : crm_flag_unit

// ### crm_core_regs.sv
`timescale 1ns/1ps
`include "crm_defs.svh"
// Overview of operation
// - 8-bit accumulator holds operands and results
// - Effective address is pointer plus offset
// - Indexed writes to code space are blocked
// - Pointer halves mapped at 0xBE, 0xBF
// - Pointer bit 11 selects data/program space
// - Counter use touches low eleven bits only
// - 11-bit program counter, reset to 0x800
// - 4-bit stack index covers 0x30-0x3F
// - Stack index resets to 0xF
// - Push subtracts two, pull adds two
// - Stack index points at next free slot
// - Call pushes return address, low first
// - Return pops address into program counter
// - Status holds C, H, Z, N, G, R
// - Carry set on carry or borrow
// - Rotates shift through the carry
// - Load bit to carry, flip carry
// - Half carry from lower nibble
// - Zero flag tracks zero result
// - Negative flag tracks result MSB
// - Pointer, stack, status memory-mapped only
// - Interrupt mask cleared by any reset
// - Unsigned offset added to low eleven bits

module crm_core_regs
  import crm_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Mode strap pin
  input wire logic prog_mode_in,
  // Execution requests
  input wire logic op_valid_in,
  input wire crm_op_t op_in,
  input wire logic [7:0] operand_in,
  input wire logic [10:0] target_in,
  input wire logic bit_in,
  // Memory-mapped register access
  input wire logic [7:0] map_addr_in,
  input wire logic map_rd_in,
  input wire logic map_wr_in,
  input wire logic [7:0] map_wdata_in,
  output logic [7:0] map_rdata_out,
  output logic map_hit_out,
  // Indexed memory access
  output logic [11:0] ea_addr_out,
  output logic ea_rd_out,
  output logic ea_wr_out,
  output logic ea_blocked_out,
  // Stack memory
  output logic [7:0] stk_addr_out,
  output logic stk_rd_out,
  output logic stk_wr_out,
  output logic [7:0] stk_wdata_out,
  input wire logic [7:0] stk_rdata_in,
  // Visible state
  output logic [7:0] accumulator_out,
  output logic [11:0] instruction_pointer_out,
  output logic [11:0] index_pointer_out,
  output logic [3:0] stack_index_out,
  output logic [7:0] condition_flags_out,
  output logic busy_out
);

  // ==========================================
  // State and reset value
  localparam crm_state_t RESET_STATE = '{
    acc: 8'h00,
    x_sel: 1'b0,
    x_low: 11'h000,
    pc: 11'(`CRM_PC_RESET & 12'h07FF),
    sp: `CRM_SP_RESET,
    flags: `CRM_FLAGS_RESET,
    seq: ST_IDLE,
    busy: 1'b0,
    tmp: 8'h00,
    ea_addr: 12'h000,
    ea_rd: 1'b0,
    ea_wr: 1'b0,
    ea_blocked: 1'b0,
    stk_addr: 8'h00,
    stk_rd: 1'b0,
    stk_wr: 1'b0,
    stk_wdata: 8'h00,
    rdata: 8'h00,
    map_hit: 1'b0,
    mode_meta: 1'b0,
    mode_sync: 1'b0
  };

  crm_state_t q;
  crm_state_t d;
  logic op_take;
  logic [7:0] fu_result;
  logic fu_carry;
  logic fu_half;
  logic fu_acc_we;
  logic fu_arith;
  logic fu_zn;

  // Stack slot address inside the RAM window
  function automatic logic [7:0] slot(input logic [3:0] idx);
    slot = `CRM_STACK_BASE | {4'h0, idx};
  endfunction : slot

  // Address decode of the mapped registers
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `CRM_ADDR_XHIGH) || (a == `CRM_ADDR_XLOW) ||
                (a == `CRM_ADDR_STACK) || (a == `CRM_ADDR_FLAGS);
  endfunction : is_mapped

  // Requests are taken only when idle and in normal mode
  assign op_take = op_valid_in && (q.seq == ST_IDLE) && !q.mode_sync;

  // ==========================================
  // Accumulator datapath
  crm_flag_unit u_flag_unit (
    .op_in(op_in),
    .acc_in(q.acc),
    .operand_in(operand_in),
    .carry_in(q.flags[`CRM_FLAG_C]),
    .result_out(fu_result),
    .carry_out(fu_carry),
    .half_out(fu_half),
    .acc_we_out(fu_acc_we),
    .arith_out(fu_arith),
    .zn_out(fu_zn)
  );

  // ==========================================
  // Next-state logic
  always_comb begin
    d = q;
    // Strap synchroniser
    d.mode_meta = prog_mode_in;
    d.mode_sync = q.mode_meta;
    d.ea_rd = 1'b0;
    d.ea_wr = 1'b0;
    d.ea_blocked = 1'b0;
    d.stk_rd = 1'b0;
    d.stk_wr = 1'b0;
    d.map_hit = 1'b0;

    // Executed operation
    if (op_take) begin
      if (fu_acc_we) begin
        d.acc = fu_result;
      end
      if (fu_arith) begin
        d.flags[`CRM_FLAG_C] = fu_carry;
        d.flags[`CRM_FLAG_H] = fu_half;
      end
      if (fu_zn) begin
        d.flags[`CRM_FLAG_Z] = (fu_result == 8'h00);
        d.flags[`CRM_FLAG_N] = fu_result[7];
      end
      if (op_in == OP_RLC || op_in == OP_RRC) begin
        d.flags[`CRM_FLAG_C] = fu_carry;
      end
      unique case (op_in)
        OP_SETC: d.flags[`CRM_FLAG_C] = 1'b1;
        OP_CLRC: d.flags[`CRM_FLAG_C] = 1'b0;
        OP_FLIPC: d.flags[`CRM_FLAG_C] = !q.flags[`CRM_FLAG_C];
        OP_BITC: d.flags[`CRM_FLAG_C] = bit_in;
        OP_SETG: d.flags[`CRM_FLAG_G] = 1'b1;
        OP_CLRG: d.flags[`CRM_FLAG_G] = 1'b0;
        OP_LDX: begin
          d.x_sel = bit_in;
          d.x_low = target_in;
        end
        OP_INCX: d.x_low = q.x_low + 11'h001;
        OP_DECX: d.x_low = q.x_low - 11'h001;
        OP_IDX_RD: begin
          d.ea_addr = {q.x_sel, q.x_low + {3'h0, operand_in}};
          d.ea_rd = 1'b1;
        end
        OP_IDX_WR: begin
          d.ea_addr = {q.x_sel, q.x_low + {3'h0, operand_in}};
          d.ea_wr = !q.x_sel;
          d.ea_blocked = q.x_sel;
        end
        OP_CALL: begin
          // Low byte of the return address goes out first
          d.stk_addr = slot(q.sp);
          d.stk_wdata = q.pc[7:0];
          d.stk_wr = 1'b1;
          d.tmp = {5'h00, q.pc[10:8]};
          d.pc = target_in;
          d.seq = ST_PUSH_HI;
        end
        OP_RET: begin
          d.stk_addr = slot(q.sp + 4'h1);
          d.stk_rd = 1'b1;
          d.seq = ST_POP_LO;
        end
        default: begin
        end
      endcase
    end

    // Call and return sequencer
    unique case (q.seq)
      ST_IDLE: begin
      end
      ST_PUSH_HI: begin
        d.stk_addr = slot(q.sp - 4'h1);
        d.stk_wdata = q.tmp;
        d.stk_wr = 1'b1;
        d.sp = q.sp - 4'h2;
        d.seq = ST_IDLE;
      end
      ST_POP_LO: begin
        d.stk_addr = slot(q.sp + 4'h2);
        d.stk_rd = 1'b1;
        d.seq = ST_POP_WAIT;
      end
      ST_POP_WAIT: begin
        d.tmp = stk_rdata_in;
        d.seq = ST_POP_END;
      end
      ST_POP_END: begin
        d.pc = {q.tmp[2:0], stk_rdata_in};
        d.sp = q.sp + 4'h2;
        d.seq = ST_IDLE;
      end
    endcase

    // Busy follows the next sequencer state so it leaves a flip-flop
    d.busy = (d.seq != ST_IDLE);

    // Mapped register read, pointer bit 11 reads as zero
    if (map_rd_in) begin
      d.map_hit = is_mapped(map_addr_in);
      unique case (map_addr_in)
        `CRM_ADDR_XHIGH: d.rdata = {5'h00, q.x_low[10:8]};
        `CRM_ADDR_XLOW: d.rdata = q.x_low[7:0];
        `CRM_ADDR_STACK: d.rdata = {4'h0, q.sp};
        `CRM_ADDR_FLAGS: d.rdata = q.flags;
        default: d.rdata = 8'h00;
      endcase
    end

    // Mapped register write wins over a same-cycle update
    if (map_wr_in) begin
      d.map_hit = is_mapped(map_addr_in);
      unique case (map_addr_in)
        `CRM_ADDR_XHIGH: begin
          d.x_sel = map_wdata_in[`CRM_XHIGH_SEL_BIT];
          d.x_low[10:8] = map_wdata_in[2:0];
        end
        `CRM_ADDR_XLOW: d.x_low[7:0] = map_wdata_in;
        `CRM_ADDR_STACK: d.sp = map_wdata_in[3:0];
        `CRM_ADDR_FLAGS: d.flags = map_wdata_in & `CRM_FLAGS_MASK;
        default: begin
        end
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // Outputs straight from the state register
  assign map_rdata_out = q.rdata;
  assign map_hit_out = q.map_hit;
  assign ea_addr_out = q.ea_addr;
  assign ea_rd_out = q.ea_rd;
  assign ea_wr_out = q.ea_wr;
  assign ea_blocked_out = q.ea_blocked;
  assign stk_addr_out = q.stk_addr;
  assign stk_rd_out = q.stk_rd;
  assign stk_wr_out = q.stk_wr;
  assign stk_wdata_out = q.stk_wdata;
  assign accumulator_out = q.acc;
  assign instruction_pointer_out = {1'b1, q.pc};
  assign index_pointer_out = {q.x_sel, q.x_low};
  assign stack_index_out = q.sp;
  assign condition_flags_out = q.flags;
  assign busy_out = q.busy;

  // ==========================================
  // Assertions
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  logic flags_wr;
  assign flags_wr = map_wr_in && (map_addr_in == `CRM_ADDR_FLAGS);

  sequence s_push_lo;
    stk_wr_out && (stk_addr_out == slot($past(stack_index_out)));
  endsequence
  sequence s_push_hi;
    stk_wr_out && (stk_addr_out == slot(stack_index_out + 4'h1));
  endsequence

  property p_reset_values;
    @(posedge clock_in) disable iff (1'b0)
    !rst_n_in |=> (stack_index_out == `CRM_SP_RESET) &&
      !condition_flags_out[`CRM_FLAG_G] && (instruction_pointer_out == `CRM_PC_RESET);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("reset values of stack index, mask or pointer wrong");

  property p_call_push;
    op_take && (op_in == OP_CALL) && !map_wr_in |=> s_push_lo ##1 s_push_hi
      ##1 (stack_index_out == $past(stack_index_out, 2) - 4'h2);
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call did not push two bytes and drop the stack index by two");

  property p_ret_pop;
    op_take && (op_in == OP_RET) && !map_wr_in |=> stk_rd_out ##1 stk_rd_out
      ##1 (!stk_rd_out && busy_out)
      ##1 (!busy_out && stack_index_out == $past(stack_index_out, 4) + 4'h2);
  endproperty
  a_ret_pop: assert property (p_ret_pop)
    else $error("return did not pop and raise the stack index by two");

  property p_code_write_blocked;
    op_take && (op_in == OP_IDX_WR) && index_pointer_out[`CRM_XSEL_BIT]
      |=> !ea_wr_out && ea_blocked_out;
  endproperty
  a_code_write_blocked: assert property (p_code_write_blocked)
    else $error("write to code space was not blocked");

  property p_ea_sum;
    op_take && (op_in == OP_IDX_RD) |=> ea_rd_out && (ea_addr_out ==
      {$past(q.x_sel), $past(q.x_low) + {3'h0, $past(operand_in)}});
  endproperty
  a_ea_sum: assert property (p_ea_sum)
    else $error("effective address is not pointer plus offset");

  property p_zero_neg;
    op_take && (op_in == OP_AND || op_in == OP_XOR) && !flags_wr
      |=> (condition_flags_out[`CRM_FLAG_Z] == (accumulator_out == 8'h00)) &&
          (condition_flags_out[`CRM_FLAG_N] == accumulator_out[7]);
  endproperty
  a_zero_neg: assert property (p_zero_neg)
    else $error("zero or negative flag does not match the result");

  property p_flip_carry;
    op_take && (op_in == OP_FLIPC) && !flags_wr
      |=> condition_flags_out[`CRM_FLAG_C] != $past(condition_flags_out[`CRM_FLAG_C]);
  endproperty
  a_flip_carry: assert property (p_flip_carry)
    else $error("flip carry did not invert the carry");

  property p_rotate;
    op_take && (op_in == OP_RLC) && !flags_wr
      |=> (condition_flags_out[`CRM_FLAG_C] == $past(accumulator_out[7])) &&
          (accumulator_out[0] == $past(condition_flags_out[`CRM_FLAG_C]));
  endproperty
  a_rotate: assert property (p_rotate)
    else $error("rotate left did not pass through the carry");

  property p_counter_keeps_sel;
    op_take && (op_in == OP_INCX) && !map_wr_in
      |=> $stable(index_pointer_out[`CRM_XSEL_BIT]);
  endproperty
  a_counter_keeps_sel: assert property (p_counter_keeps_sel)
    else $error("pointer count changed the space select bit");

  property p_inc_keeps_carry;
    op_take && (op_in == OP_INC) && !flags_wr
      |=> $stable(condition_flags_out[`CRM_FLAG_C]) &&
          $stable(condition_flags_out[`CRM_FLAG_H]);
  endproperty
  a_inc_keeps_carry: assert property (p_inc_keeps_carry)
    else $error("increment disturbed carry or half carry");

endmodule : crm_core_regs

// ### crm_core_regs_tb.sv
`timescale 1ns/1ps
`include "crm_defs.svh"

module tb
  import crm_pkg::*;
;
  // ==========================================
  // Bench signals
  localparam time DLY = 1;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic prog_mode_in = 1'b0;
  logic op_valid_in = 1'b0;
  crm_op_t op_in = OP_NOP;
  logic [7:0] operand_in = 8'h00;
  logic [10:0] target_in = 11'h000;
  logic bit_in = 1'b0;
  logic [7:0] map_addr_in = 8'h00;
  logic map_rd_in = 1'b0;
  logic map_wr_in = 1'b0;
  logic [7:0] map_wdata_in = 8'h00;
  logic [7:0] stk_rdata_in = 8'h00;
  logic [7:0] map_rdata_out, stk_addr_out, stk_wdata_out, accumulator_out, condition_flags_out;
  logic [11:0] ea_addr_out, instruction_pointer_out, index_pointer_out;
  logic [3:0] stack_index_out;
  logic map_hit_out, ea_rd_out, ea_wr_out, ea_blocked_out, stk_rd_out, stk_wr_out, busy_out;
  int err_total = 0;
  int num_checks = 0;

  // Clock at 100 MHz
  always #5 clock_in = ~clock_in;

  // Device under test
  crm_core_regs crm_core_regs_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .prog_mode_in(prog_mode_in), .op_valid_in(op_valid_in), .op_in(op_in),
    .operand_in(operand_in), .target_in(target_in), .bit_in(bit_in),
    .map_addr_in(map_addr_in), .map_rd_in(map_rd_in), .map_wr_in(map_wr_in),
    .map_wdata_in(map_wdata_in), .map_rdata_out(map_rdata_out), .map_hit_out(map_hit_out),
    .ea_addr_out(ea_addr_out), .ea_rd_out(ea_rd_out), .ea_wr_out(ea_wr_out),
    .ea_blocked_out(ea_blocked_out), .stk_addr_out(stk_addr_out), .stk_rd_out(stk_rd_out),
    .stk_wr_out(stk_wr_out), .stk_wdata_out(stk_wdata_out), .stk_rdata_in(stk_rdata_in),
    .accumulator_out(accumulator_out), .instruction_pointer_out(instruction_pointer_out),
    .index_pointer_out(index_pointer_out), .stack_index_out(stack_index_out),
    .condition_flags_out(condition_flags_out), .busy_out(busy_out));

  // ==========================================
  // Compare tasks
  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit

  // ==========================================
  // Drivers; every task starts and ends just after a rising edge
  // A request stays up until the next request or an explicit drop
  task automatic do_op(input crm_op_t op, input logic [7:0] opd, input logic [10:0] tgt,
                       input logic b);
    op_valid_in = 1'b1;
    op_in = op;
    operand_in = opd;
    target_in = tgt;
    bit_in = b;
    @(posedge clock_in);
    #DLY;
  endtask : do_op

  task automatic map_acc(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                         input logic exp_hit);
    map_wr_in = wr;
    map_rd_in = ~wr;
    map_addr_in = addr;
    map_wdata_in = data;
    @(posedge clock_in);
    #DLY;
    chk_bit(map_hit_out, exp_hit, "map hit");
  endtask : map_acc

  task automatic map_rd_chk(input logic [7:0] addr, input logic [7:0] exp, input logic hit);
    map_acc(1'b0, addr, 8'h00, hit);
    chk_val(map_rdata_out, exp, "map read");
  endtask : map_rd_chk

  task automatic alu(input crm_op_t op, input logic [7:0] opd, input logic b,
                     input logic [7:0] exp_acc, input logic [7:0] exp_flags);
    do_op(op, opd, 11'h000, b);
    chk_val(accumulator_out, exp_acc, "accumulator");
    chk_val(condition_flags_out, exp_flags, "flags");
  endtask : alu

  task automatic wait_idle;
    for (int i = 0; i < 6 && busy_out !== 1'b0; i++) begin
      @(posedge clock_in);
      #DLY;
    end
    chk_bit(busy_out, 1'b0, "busy released");
  endtask : wait_idle

  // ==========================================
  // Scenarios
  task automatic t_reset;
    chk_val(accumulator_out, 8'h00, "acc reset");
    chk_val(instruction_pointer_out, `CRM_PC_RESET, "pc reset");
    chk_val(stack_index_out, `CRM_SP_RESET, "sp reset");
    chk_val(condition_flags_out, `CRM_FLAGS_RESET, "flags reset");
    chk_bit(busy_out, 1'b0, "busy reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_map;
    map_acc(1'b1, `CRM_ADDR_XLOW, 8'hA5, 1'b1);
    chk_val(index_pointer_out, 12'h0A5, "pointer low write");
    map_acc(1'b1, `CRM_ADDR_XHIGH, 8'h0B, 1'b1);
    chk_val(index_pointer_out, 12'hBA5, "pointer high write");
    map_rd_chk(`CRM_ADDR_XHIGH, 8'h03, 1'b1);
    map_rd_chk(`CRM_ADDR_XLOW, 8'hA5, 1'b1);
    map_acc(1'b1, `CRM_ADDR_STACK, 8'h09, 1'b1);
    chk_val(stack_index_out, 4'h9, "stack index write");
    map_rd_chk(`CRM_ADDR_STACK, 8'h09, 1'b1);
    map_acc(1'b1, `CRM_ADDR_FLAGS, 8'hFF, 1'b1);
    map_rd_chk(`CRM_ADDR_FLAGS, `CRM_FLAGS_MASK, 1'b1);
    map_acc(1'b1, 8'h40, 8'h77, 1'b0);
    map_rd_chk(8'h40, 8'h00, 1'b0);
    map_acc(1'b1, `CRM_ADDR_FLAGS, 8'h00, 1'b1);
    map_acc(1'b1, `CRM_ADDR_STACK, 8'h0F, 1'b1);
    map_wr_in = 1'b0;
    map_rd_in = 1'b0;
    $display("test mapped registers done");
  endtask : t_map

  task automatic t_index;
    do_op(OP_LDX, 8'h00, 11'h7F0, 1'b1);
    chk_val(index_pointer_out, 12'hFF0, "pointer load");
    do_op(OP_IDX_RD, 8'h20, 11'h000, 1'b0);
    chk_bit(ea_rd_out, 1'b1, "indexed read strobe");
    chk_val(ea_addr_out, 12'h810, "indexed wrap address");
    do_op(OP_IDX_WR, 8'h05, 11'h000, 1'b0);
    chk_bit(ea_wr_out, 1'b0, "code write suppressed");
    chk_bit(ea_blocked_out, 1'b1, "code write refused");
    do_op(OP_LDX, 8'h00, 11'h0F0, 1'b0);
    do_op(OP_IDX_WR, 8'h0F, 11'h000, 1'b0);
    chk_bit(ea_wr_out, 1'b1, "data write strobe");
    chk_val(ea_addr_out, 12'h0FF, "data write address");
    chk_bit(ea_blocked_out, 1'b0, "data write allowed");
    do_op(OP_LDX, 8'h00, 11'h7FF, 1'b1);
    do_op(OP_INCX, 8'h00, 11'h000, 1'b0);
    chk_val(index_pointer_out, 12'h800, "counter keeps select");
    chk_val(condition_flags_out, 8'h00, "pointer ops keep flags");
    $display("test index pointer done");
  endtask : t_index

  task automatic t_alu;
    alu(OP_LDA, 8'h0F, 1'b0, 8'h0F, 8'h00);
    alu(OP_ADD, 8'h01, 1'b0, 8'h10, 8'h02);
    alu(OP_ADD, 8'hF0, 1'b0, 8'h00, 8'h05);
    alu(OP_LDA, 8'h80, 1'b0, 8'h80, 8'h09);
    alu(OP_CLRC, 8'h00, 1'b0, 8'h80, 8'h08);
    alu(OP_RLC, 8'h00, 1'b0, 8'h00, 8'h05);
    alu(OP_RRC, 8'h00, 1'b0, 8'h80, 8'h08);
    alu(OP_SETC, 8'h00, 1'b0, 8'h80, 8'h09);
    alu(OP_FLIPC, 8'h00, 1'b0, 8'h80, 8'h08);
    alu(OP_BITC, 8'h00, 1'b1, 8'h80, 8'h09);
    alu(OP_BITC, 8'h00, 1'b0, 8'h80, 8'h08);
    alu(OP_SUBC, 8'h01, 1'b0, 8'h7F, 8'h02);
    alu(OP_AND, 8'h0F, 1'b0, 8'h0F, 8'h02);
    alu(OP_INC, 8'h00, 1'b0, 8'h10, 8'h02);
    alu(OP_XOR, 8'h10, 1'b0, 8'h00, 8'h06);
    alu(OP_OR, 8'h81, 1'b0, 8'h81, 8'h0A);
    alu(OP_DEC, 8'h00, 1'b0, 8'h80, 8'h0A);
    alu(OP_CLR, 8'h00, 1'b0, 8'h00, 8'h06);
    alu(OP_SETC, 8'h00, 1'b0, 8'h00, 8'h07);
    alu(OP_ADC, 8'h0F, 1'b0, 8'h10, 8'h02);
    $display("test flags done");
  endtask : t_alu

  task automatic t_strap;
    op_valid_in = 1'b0;
    prog_mode_in = 1'b1;
    repeat (3) @(posedge clock_in);
    #DLY;
    do_op(OP_LDA, 8'h3C, 11'h000, 1'b0);
    op_valid_in = 1'b0;
    prog_mode_in = 1'b0;
    chk_val(accumulator_out, 8'h10, "op refused while strapped");
    repeat (3) @(posedge clock_in);
    #DLY;
    $display("test programming strap done");
  endtask : t_strap

  task automatic do_call(input logic [10:0] tgt, input logic [3:0] sp0, input logic [10:0] pc0);
    do_op(OP_CALL, 8'h00, tgt, 1'b0);
    op_valid_in = 1'b0;
    chk_bit(stk_wr_out, 1'b1, "push strobe low byte");
    chk_val(stk_addr_out, {4'h3, sp0}, "push slot low byte");
    chk_val(stk_wdata_out, pc0[7:0], "push low byte");
    @(posedge clock_in);
    #DLY;
    chk_bit(stk_wr_out, 1'b1, "push strobe high byte");
    chk_val(stk_addr_out, {4'h3, sp0 - 4'h1}, "push slot high byte");
    chk_val(stk_wdata_out, {5'b00000, pc0[10:8]}, "push high byte");
    wait_idle();
    chk_val(stack_index_out, sp0 - 4'h2, "push moves index");
    chk_val(instruction_pointer_out, {1'b1, tgt}, "call target");
  endtask : do_call

  task automatic do_ret(input logic [3:0] sp0, input logic [10:0] pc_exp);
    do_op(OP_RET, 8'h00, 11'h000, 1'b0);
    op_valid_in = 1'b0;
    chk_bit(stk_rd_out, 1'b1, "pull strobe high byte");
    chk_val(stk_addr_out, {4'h3, sp0 + 4'h1}, "pull slot high byte");
    @(posedge clock_in);
    #DLY;
    stk_rdata_in = {5'b00000, pc_exp[10:8]};
    chk_val(stk_addr_out, {4'h3, sp0 + 4'h2}, "pull slot low byte");
    @(posedge clock_in);
    #DLY;
    stk_rdata_in = pc_exp[7:0];
    @(posedge clock_in);
    #DLY;
    stk_rdata_in = ~pc_exp[7:0];
    wait_idle();
    chk_val(instruction_pointer_out, {1'b1, pc_exp}, "return address");
    chk_val(stack_index_out, sp0 + 4'h2, "pull moves index");
  endtask : do_ret

  task automatic t_stack;
    do_call(11'h456, 4'hF, 11'h000);
    do_call(11'h123, 4'hD, 11'h456);
    do_ret(4'hB, 11'h456);
    $display("test call and return done");
  endtask : t_stack

  task automatic t_rerun_reset;
    do_op(OP_SETG, 8'h00, 11'h000, 1'b0);
    chk_bit(condition_flags_out[`CRM_FLAG_G], 1'b1, "mask set by software");
    do_op(OP_CLRG, 8'h00, 11'h000, 1'b0);
    chk_bit(condition_flags_out[`CRM_FLAG_G], 1'b0, "mask cleared by software");
    do_op(OP_SETG, 8'h00, 11'h000, 1'b0);
    op_valid_in = 1'b0;
    rst_n_in = 1'b0;
    @(posedge clock_in);
    #DLY;
    rst_n_in = 1'b1;
    chk_bit(condition_flags_out[`CRM_FLAG_G], 1'b0, "mask cleared by reset");
    chk_val(stack_index_out, `CRM_SP_RESET, "sp after second reset");
    chk_val(instruction_pointer_out, `CRM_PC_RESET, "pc after second reset");
    $display("test second reset done");
  endtask : t_rerun_reset

  // ==========================================
  // Verdict and run control
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // Watchdog, far beyond the 65 or so cycles the tests take
  initial begin
    #(5000 * 10);
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    summarize();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clock_in);
    #DLY;
    rst_n_in = 1'b1;
    t_reset();
    t_map();
    t_index();
    t_alu();
    t_strap();
    t_stack();
    t_rerun_reset();
    summarize();
  end
endmodule : tb
